// file: rtl/arc_trip_breaker_failure_logic.sv
`timescale 1ns/1ps


module arc_trip_breaker_failure_logic
  import arc_trip_pkg::*;
#(
  parameter int             TICK_CYCLES     = `TICK_CYCLES,
  parameter logic [3:0]     GROUP_ONE_ZONES = 4'h3,
  parameter logic [3:0]     GROUP_TWO_ZONES = 4'hC
)
(
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         clkEn,
  input  wire logic [3:0]   lightZone,
  input  wire logic [3:0]   sensorFault,
  input  wire logic         overcurrentLocal,
  input  wire logic         currentIoIndication,
  input  wire logic         arc_in_group_one,
  input  wire logic         arc_in_group_two,
  input  wire logic         overcurrent_link_signal_in,
  input  wire logic         supplyValid,
  input  wire logic         latchSwitch,
  input  wire logic         lightOnlySwitch,
  input  wire logic         breaker_failure_enable_switch,
  input  wire logic         breaker_failure_delay_switch,
  input  wire logic         tripReset,
  input  wire logic         watchdogKick,
  input  wire logic [7:0]   pickupSetOuter,
  input  wire logic [7:0]   pickupSetMiddle,
  input  wire logic [7:0]   phaseMagL1,
  input  wire logic [7:0]   phaseMagL2,
  input  wire logic [7:0]   phaseMagL3,
  output logic [3:0]        tripRelay,
  output logic              arcAlarm,
  output logic              arc_out_group_one,
  output logic              arc_out_group_two,
  output logic              overcurrent_link_signal_out,
  output logic              overcurrentLinkOeN,
  output logic              unbalanceAlarm,
  output logic              controllerFaultAlarm,
  output logic              componentFaultAlarm,
  output logic              self_supervision_fault_relay,
  output logic              controllerRestart
);

  // ****************************************************************
  // State and timers
  // ****************************************************************
  trip_state_t             state_reg;
  trip_state_t             state_next;
  logic [2:0]              timerRun;
  logic [2:0]              timerExpired;
  logic [`TIMER_WIDTH-1:0] timerLimit [3];

  logic [`SYNC_WIDTH-1:0]  pinVector;
  logic [`SYNC_WIDTH-1:0]  pins;
  logic [3:0]              validZones;
  logic                    anyZone;
  logic                    ocLocal;
  logic                    ocRemote;
  logic                    ocAny;
  logic                    groupOneLight;
  logic                    groupTwoLight;
  logic                    activeOne;
  logic                    activeTwo;
  logic                    latchAllowed;
  logic                    bfEnabled;
  logic                    primaryTrip;
  logic                    twoPhase;
  logic [7:0]              magMax;
  logic [7:0]              magMin;
  logic [7:0]              setMax;
  logic [7:0]              setMin;
  logic                    deviationHigh;

  assign pinVector = {breaker_failure_delay_switch, breaker_failure_enable_switch, lightOnlySwitch,
                      latchSwitch, supplyValid, overcurrent_link_signal_in, arc_in_group_two,
                      arc_in_group_one, currentIoIndication, overcurrentLocal, sensorFault, lightZone};

  // The timers hold the breaker-failure, unbalance and watchdog delays.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gTimer
      tick_timer uTimer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .tick    (state_reg.tick),
        .run     (timerRun[gi]),
        .limit   (timerLimit[gi]),
        .expired (timerExpired[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Criteria from synchronised pins
  // ****************************************************************
  always_comb begin
    pins          = state_reg.sync2;
    validZones    = pins[`SY_ZONE_LSB +: 4] & ~pins[`SY_FAULT_LSB +: 4];
    anyZone       = |validZones;
    ocLocal       = pins[`SY_OC_LOCAL];
    // The link carries levels only, so no address is decoded.
    ocRemote      = pins[`SY_OC_LINK_IN] | pins[`SY_IO_IND];
    ocAny         = ocLocal | ocRemote;
    groupOneLight = |(validZones & GROUP_ONE_ZONES) | pins[`SY_ARC_IN_ONE];
    groupTwoLight = |(validZones & GROUP_TWO_ZONES) | pins[`SY_ARC_IN_TWO];
    activeOne     = groupOneLight && (ocAny || pins[`SY_LIGHT_ONLY_SW]);
    activeTwo     = groupTwoLight && (ocAny || pins[`SY_LIGHT_ONLY_SW]);
    latchAllowed  = !pins[`SY_LATCH_SW] && (state_reg.supState != SUP_FAILED);
    bfEnabled     = !pins[`SY_BF_ENABLE_SW];
    primaryTrip   = state_reg.trip[0] | state_reg.trip[2];
  end

  // ****************************************************************
  // Unbalance measurement
  // ****************************************************************
  always_comb begin
    setMax   = (pickupSetOuter > pickupSetMiddle) ? pickupSetOuter : pickupSetMiddle;
    setMin   = (pickupSetOuter > pickupSetMiddle) ? pickupSetMiddle : pickupSetOuter;
    // Settings far apart mean only the outer phases are wired.
    twoPhase = ({4'h0, setMin} * 12'(`DEVIATION_SCALE)) < {4'h0, setMax};
    magMax   = (phaseMagL1 > phaseMagL3) ? phaseMagL1 : phaseMagL3;
    magMin   = (phaseMagL1 > phaseMagL3) ? phaseMagL3 : phaseMagL1;
    if (!twoPhase) begin
      if (phaseMagL2 > magMax) begin
        magMax = phaseMagL2;
      end
      if (phaseMagL2 < magMin) begin
        magMin = phaseMagL2;
      end
    end
    deviationHigh = ({4'h0, magMin} * 12'(`DEVIATION_SCALE)) < {4'h0, magMax};
  end

  // ****************************************************************
  // Timer control
  // ****************************************************************
  always_comb begin
    timerRun[0]   = bfEnabled && primaryTrip;
    timerLimit[0] = pins[`SY_BF_DELAY_SW] ? `TIMER_WIDTH'(`BF_DELAY_LONG_TICKS)
                                          : `TIMER_WIDTH'(`BF_DELAY_SHORT_TICKS);
    timerRun[1]   = deviationHigh;
    timerLimit[1] = `TIMER_WIDTH'(`UNBAL_DELAY_TICKS);
    timerRun[2]   = !watchdogKick && (state_reg.supState == SUP_RUN || state_reg.supState == SUP_RETRY);
    timerLimit[2] = `TIMER_WIDTH'(`WDOG_TIMEOUT_TICKS);
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next       = state_reg;
    state_next.sync1 = pinVector;
    state_next.sync2 = state_reg.sync1;

    state_next.tick = 1'b0;
    if (state_reg.tickCount == 18'(TICK_CYCLES - 1)) begin
      state_next.tickCount = 18'h00000;
      state_next.tick      = 1'b1;
    end else begin
      state_next.tickCount = state_reg.tickCount + 18'h00001;
    end

    // A reset request loses to a new activation so no trip is dropped.
    if (tripReset || !latchAllowed) begin
      state_next.latchOne = 1'b0;
      state_next.latchTwo = 1'b0;
    end
    if (latchAllowed && activeOne) begin
      state_next.latchOne = 1'b1;
    end
    if (latchAllowed && activeTwo) begin
      state_next.latchTwo = 1'b1;
    end

    if (!primaryTrip || !bfEnabled) begin
      state_next.bfLocal  = 1'b0;
      state_next.bfRemote = 1'b0;
    end else if (timerExpired[0]) begin
      if (ocLocal && anyZone) begin
        state_next.bfLocal = 1'b1;
      end
      if (ocRemote && anyZone) begin
        state_next.bfRemote = 1'b1;
      end
    end

    state_next.restart = 1'b0;
    case (state_reg.supState)
      SUP_RUN: begin
        if (timerExpired[2] && !watchdogKick) begin
          state_next.supState = SUP_RESTART;
        end
      end
      SUP_RESTART: begin
        state_next.restart  = 1'b1;
        state_next.supState = SUP_RETRY;
      end
      SUP_RETRY: begin
        if (watchdogKick) begin
          state_next.supState = SUP_RUN;
        end else if (timerExpired[2]) begin
          state_next.supState = SUP_FAILED;
        end
      end
      SUP_FAILED: begin
        state_next.supState = SUP_FAILED;
      end
      default: begin
        state_next.supState = SUP_FAILED;
      end
    endcase

    // Activation passes in three clock cycles, far inside the operating time.
    state_next.trip[0] = activeOne || state_next.latchOne;
    state_next.trip[2] = activeTwo || state_next.latchTwo;
    state_next.trip[1] = bfEnabled ? state_next.bfLocal : state_next.trip[0];
    state_next.trip[3] = bfEnabled ? state_next.bfRemote : state_next.trip[2];

    state_next.arcAlarm        = state_next.trip[0] | state_next.trip[2];
    state_next.arcOutOne       = |(validZones & GROUP_ONE_ZONES);
    state_next.arcOutTwo       = |(validZones & GROUP_TWO_ZONES);
    state_next.ocLinkOeN       = !ocLocal;
    state_next.unbalanceAlarm  = timerExpired[1];
    state_next.controllerFault = (state_next.supState == SUP_FAILED);
    state_next.componentFault  = |pins[`SY_FAULT_LSB +: 4];
    // The relay is energised in health, so a dead supply drops it.
    state_next.faultRelay      = pins[`SY_SUPPLY_OK] && !state_next.controllerFault;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg          <= '0;
      state_reg.supState <= SUP_RUN;
      state_reg.ocLinkOeN <= 1'b1;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign tripRelay                    = state_reg.trip;
  assign arcAlarm                     = state_reg.arcAlarm;
  assign arc_out_group_one            = state_reg.arcOutOne;
  assign arc_out_group_two            = state_reg.arcOutTwo;
  assign overcurrent_link_signal_out  = 1'b1;
  assign overcurrentLinkOeN           = state_reg.ocLinkOeN;
  assign unbalanceAlarm               = state_reg.unbalanceAlarm;
  assign controllerFaultAlarm         = state_reg.controllerFault;
  assign componentFaultAlarm          = state_reg.componentFault;
  assign self_supervision_fault_relay = state_reg.faultRelay;
  assign controllerRestart            = state_reg.restart;

endmodule

// file: rtl/arc_trip_params.svh
`ifndef ARC_TRIP_PARAMS_SVH
`define ARC_TRIP_PARAMS_SVH

// ****************************************************************
// Clock and tick
// ****************************************************************
`define CLK_RATE_MHZ         200
`define TICK_PERIOD_US       1000
`define TICK_CYCLES          (`CLK_RATE_MHZ * `TICK_PERIOD_US)

// ****************************************************************
// Delays
// ****************************************************************
`define BF_DELAY_SHORT_MS    100
`define BF_DELAY_LONG_MS     150
`define BF_DELAY_SHORT_TICKS (`BF_DELAY_SHORT_MS * 1000 / `TICK_PERIOD_US)
`define BF_DELAY_LONG_TICKS  (`BF_DELAY_LONG_MS * 1000 / `TICK_PERIOD_US)
`define UNBAL_DELAY_S        10
`define UNBAL_DELAY_TICKS    (`UNBAL_DELAY_S * 1000000 / `TICK_PERIOD_US)
`define WDOG_TIMEOUT_MS      50
`define WDOG_TIMEOUT_TICKS   (`WDOG_TIMEOUT_MS * 1000 / `TICK_PERIOD_US)
`define ARC_OPERATE_MS       7

// ****************************************************************
// Unbalance threshold
// ****************************************************************
`define DEVIATION_PERCENT    90
`define DEVIATION_SCALE      (100 / (100 - `DEVIATION_PERCENT))

// ****************************************************************
// Widths and positions of synchronised pins
// ****************************************************************
`define ZONE_COUNT           4
`define TIMER_WIDTH          14
`define SYNC_WIDTH           18
`define SY_ZONE_LSB          0
`define SY_FAULT_LSB         4
`define SY_OC_LOCAL          8
`define SY_IO_IND            9
`define SY_ARC_IN_ONE        10
`define SY_ARC_IN_TWO        11
`define SY_OC_LINK_IN        12
`define SY_SUPPLY_OK         13
`define SY_LATCH_SW          14
`define SY_LIGHT_ONLY_SW     15
`define SY_BF_ENABLE_SW      16
`define SY_BF_DELAY_SW       17

// ****************************************************************
// Reset values
// ****************************************************************
`define TIMER_COUNT_RESET    14'h0000
`define SYNC_RESET           18'h00000

`endif

// file: rtl/arc_trip_pkg.sv
`include "arc_trip_params.svh"

package arc_trip_pkg;

  typedef enum logic [1:0] {
    SUP_RUN,
    SUP_RESTART,
    SUP_RETRY,
    SUP_FAILED
  } supervision_state_t;

  typedef struct packed {
    logic [`TIMER_WIDTH-1:0] count;
    logic                    expired;
  } timer_state_t;

  typedef struct packed {
    logic [`SYNC_WIDTH-1:0] sync1;
    logic [`SYNC_WIDTH-1:0] sync2;
    logic [17:0]            tickCount;
    logic                   tick;
    logic                   latchOne;
    logic                   latchTwo;
    logic                   bfLocal;
    logic                   bfRemote;
    supervision_state_t     supState;
    logic [3:0]             trip;
    logic                   arcAlarm;
    logic                   arcOutOne;
    logic                   arcOutTwo;
    logic                   ocLinkOeN;
    logic                   unbalanceAlarm;
    logic                   controllerFault;
    logic                   componentFault;
    logic                   faultRelay;
    logic                   restart;
  } trip_state_t;

endpackage

// file: rtl/tick_timer.sv
`timescale 1ns/1ps

module tick_timer
  import arc_trip_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic                    clkEn,
  input  wire logic                    tick,
  input  wire logic                    run,
  input  wire logic [`TIMER_WIDTH-1:0] limit,
  output logic                         expired
);

  timer_state_t state_reg;
  timer_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (!run) begin
      state_next.count = `TIMER_COUNT_RESET;
    end else if (tick && state_reg.count < limit) begin
      state_next.count = state_reg.count + `TIMER_WIDTH'(1);
    end
    state_next.expired = run && (state_next.count >= limit);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign expired = state_reg.expired;

endmodule

// file: sim/arc_trip_props.sv
`timescale 1ns/1ps

// ****************************************************************
// Port checker
// ****************************************************************
module arc_trip_props #(
  parameter int TICK_CYCLES = 4
)
(
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [3:0] lightZone,
  input wire logic [3:0] sensorFault,
  input wire logic       overcurrentLocal,
  input wire logic       arc_in_group_one,
  input wire logic       supplyValid,
  input wire logic       breaker_failure_enable_switch,
  input wire logic [3:0] tripRelay,
  input wire logic       arcAlarm,
  input wire logic       arc_out_group_one,
  input wire logic       overcurrentLinkOeN,
  input wire logic       self_supervision_fault_relay,
  input wire logic       controllerRestart,
  input wire logic       controllerFaultAlarm
);
  int unsigned primCnt;

  // Cycles the main relays have been closed, for the backup delay floor.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !(tripRelay[0] || tripRelay[2])) begin
      primCnt <= 0;
    end else begin
      primCnt <= primCnt + 1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_alarm; arcAlarm == (tripRelay[0] || tripRelay[2]); endproperty
  a_alarm: assert property (p_alarm) else $error("arc alarm differs from main relays");
  property p_cause; $rose(tripRelay[0]) |-> $past(|(lightZone[1:0] & ~sensorFault[1:0]) || arc_in_group_one, 3);
  endproperty
  a_cause: assert property (p_cause) else $error("relay one closed without light");
  property p_operate; (lightZone[0] && overcurrentLocal && !sensorFault[0]) [*3] |=> tripRelay[0]; endproperty
  a_operate: assert property (p_operate) else $error("relay one late");
  property p_mask; (sensorFault[1:0] == 2'h3 && !arc_in_group_one) [*4] |=> !arc_out_group_one; endproperty
  a_mask: assert property (p_mask) else $error("faulted sensor still active");
  property p_supply; !supplyValid [*3] |=> !self_supervision_fault_relay; endproperty
  a_supply: assert property (p_supply) else $error("fault relay held without supply");
  property p_release; $fell(tripRelay[0]) && !tripRelay[2] |-> ##[0:1] !tripRelay[1]; endproperty
  a_release: assert property (p_release) else $error("backup relay held after release");
  property p_delay; $rose(tripRelay[1] || tripRelay[3]) && !breaker_failure_enable_switch |->
    primCnt >= 99 * TICK_CYCLES; endproperty
  a_delay: assert property (p_delay) else $error("backup relay too early");
  property p_copy; breaker_failure_enable_switch [*4] |-> tripRelay[1] == tripRelay[0]; endproperty
  a_copy: assert property (p_copy) else $error("fast trip copy wrong");
  property p_pulse; controllerRestart |=> !controllerRestart; endproperty
  a_pulse: assert property (p_pulse) else $error("restart not a pulse");
  property p_perm; controllerFaultAlarm |=> controllerFaultAlarm && !self_supervision_fault_relay; endproperty
  a_perm: assert property (p_perm) else $error("controller fault not permanent");
  property p_drive; overcurrentLocal [*3] |=> !overcurrentLinkOeN; endproperty
  a_drive: assert property (p_drive) else $error("overcurrent not driven on link");
endmodule

bind arc_trip_breaker_failure_logic arc_trip_props #(.TICK_CYCLES(TICK_CYCLES)) arc_trip_props_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .lightZone(lightZone), .sensorFault(sensorFault),
  .overcurrentLocal(overcurrentLocal), .arc_in_group_one(arc_in_group_one), .supplyValid(supplyValid),
  .breaker_failure_enable_switch(breaker_failure_enable_switch), .tripRelay(tripRelay), .arcAlarm(arcAlarm),
  .arc_out_group_one(arc_out_group_one), .overcurrentLinkOeN(overcurrentLinkOeN),
  .self_supervision_fault_relay(self_supervision_fault_relay), .controllerRestart(controllerRestart),
  .controllerFaultAlarm(controllerFaultAlarm));

// file: sim/link_peer_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Peer central unit on the criteria link
// ****************************************************************
module link_peer_model (
  input  wire logic clk_sys,
  input  wire logic arcOneCmd,
  input  wire logic arcTwoCmd,
  input  wire logic ocCmd,
  input  wire logic dutOcOut,
  input  wire logic dutOcOeN,
  output logic      arcToDutOne,
  output logic      arcToDutTwo,
  output logic      ocWire
);
  // Plain levels with no address, changed just after the edge.
  always_ff @(posedge clk_sys) begin
    arcToDutOne <= arcOneCmd;
    arcToDutTwo <= arcTwoCmd;
  end
  // Shared line is a wired-or with a pull-down, so the device hears its own drive too.
  assign ocWire = ocCmd | (!dutOcOeN & dutOcOut);
endmodule

// file: sim/arc_trip_breaker_failure_logic_tb.sv
`timescale 1ns/1ps

module arc_trip_breaker_failure_logic_tb;
  logic       clk_sys = 1'h0, reset_n = 1'h0, latchSwitch = 1'h1, lightOnly = 1'h0, bfOff = 1'h0, bfLong = 1'h0;
  logic [3:0] lightZone = 4'h0, sensorFault = 4'h0, tripRelay;
  logic       ocLocal = 1'h0, ioInd = 1'h0, supplyValid = 1'h1, tripReset = 1'h0, watchdogKick = 1'h0;
  logic [7:0] setMiddle = 8'h64, magL2 = 8'h64;
  logic       peerArcOne = 1'h0, peerOc = 1'h0, arcInOne, arcInTwo, ocWire, ocOut, ocOeN;
  logic       arcAlarm, outOne, outTwo, unbal, ctrlFault, compFault, faultRelay, restart;
  logic       kickOn = 1'h1, restartSeen = 1'h0, clkEn = 1'h1;
  int         errCount = 0, nChecks = 0, cycles = 0;

  arc_trip_breaker_failure_logic #(.TICK_CYCLES(4)) arc_trip_breaker_failure_logic_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .lightZone(lightZone), .sensorFault(sensorFault),
    .overcurrentLocal(ocLocal), .currentIoIndication(ioInd), .arc_in_group_one(arcInOne),
    .arc_in_group_two(arcInTwo), .overcurrent_link_signal_in(ocWire), .supplyValid(supplyValid),
    .latchSwitch(latchSwitch), .lightOnlySwitch(lightOnly), .breaker_failure_enable_switch(bfOff),
    .breaker_failure_delay_switch(bfLong), .tripReset(tripReset), .watchdogKick(watchdogKick),
    .pickupSetOuter(8'h64), .pickupSetMiddle(setMiddle), .phaseMagL1(8'h64), .phaseMagL2(magL2),
    .phaseMagL3(8'h64), .tripRelay(tripRelay), .arcAlarm(arcAlarm), .arc_out_group_one(outOne),
    .arc_out_group_two(outTwo), .overcurrent_link_signal_out(ocOut), .overcurrentLinkOeN(ocOeN),
    .unbalanceAlarm(unbal), .controllerFaultAlarm(ctrlFault), .componentFaultAlarm(compFault),
    .self_supervision_fault_relay(faultRelay), .controllerRestart(restart));

  link_peer_model link_peer_model_i (
    .clk_sys(clk_sys), .arcOneCmd(peerArcOne), .arcTwoCmd(1'h0), .ocCmd(peerOc), .dutOcOut(ocOut),
    .dutOcOeN(ocOeN), .arcToDutOne(arcInOne), .arcToDutTwo(arcInTwo), .ocWire(ocWire));

  // ****************************************************************
  // Clock, watchdog and timeout
  // ****************************************************************
  always #2.5 clk_sys = ~clk_sys;

  always @(negedge clk_sys) watchdogKick <= kickOn && !watchdogKick;

  always @(posedge clk_sys) begin
    if (restart === 1'h1) begin
      restartSeen <= 1'h1;
    end
    cycles++;
    // The two unbalance waits dominate the run, about 82000 cycles.
    if (cycles == 95000) begin
      errCount++;
      tallyAndFinish();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic drive(input logic [3:0] zones, input logic oc, input int n);
    lightZone = zones;
    ocLocal = oc;
    cyc(n);
  endtask

  task automatic chk(input logic [3:0] act, input logic [3:0] exp);
    nChecks++;
    if (act !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic tallyAndFinish();
    $display("mismatches %0d of %0d checks", errCount, nChecks);
    if (errCount == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    cyc(20);
    reset_n = 1'h1;
    cyc(4);
    chk(tripRelay, 4'h0);
    chk({2'h0, faultRelay, ocOeN}, 4'h3);
    drive(4'h1, 1'h0, 6);
    chk(tripRelay, 4'h0);
    for (int z = 0; z < 4; z++) begin
      drive(4'h1 << z, 1'h1, 3);
      chk(tripRelay & 4'h5, (z < 2) ? 4'h1 : 4'h4);
      chk({arcAlarm, outOne, outTwo, ocOeN}, (z < 2) ? 4'hC : 4'hA);
      drive(4'h0, 1'h0, 4);
      chk(tripRelay, 4'h0);
    end
    // A frozen block must hold a follow-mode trip although the activation is gone.
    drive(4'h1, 1'h1, 3);
    clkEn = 1'h0;
    drive(4'h0, 1'h0, 6);
    chk(tripRelay, 4'h1);
    clkEn = 1'h1;
    drive(4'h0, 1'h0, 4);
    chk(tripRelay, 4'h0);
    lightOnly = 1'h1;
    drive(4'h4, 1'h0, 3);
    chk(tripRelay, 4'h4);
    lightOnly = 1'h0;
    drive(4'h0, 1'h0, 4);
    sensorFault = 4'h3;
    drive(4'h1, 1'h1, 6);
    chk({tripRelay[0], compFault, 2'h0}, 4'h4);
    sensorFault = 4'h0;
    drive(4'h0, 1'h0, 4);
    latchSwitch = 1'h0;
    drive(4'h1, 1'h1, 4);
    drive(4'h0, 1'h0, 6);
    chk(tripRelay, 4'h1);
    tripReset = 1'h1;
    cyc(4);
    tripReset = 1'h0;
    chk(tripRelay, 4'h0);
    latchSwitch = 1'h1;
    drive(4'h1, 1'h1, 391);
    chk({2'h0, tripRelay[1:0]}, 4'h1);
    cyc(20);
    chk({2'h0, tripRelay[1:0]}, 4'h3);
    drive(4'h0, 1'h0, 4);
    chk(tripRelay, 4'h0);
    bfLong = 1'h1;
    peerOc = 1'h1;
    drive(4'h4, 1'h0, 594);
    chk(tripRelay, 4'h4);
    cyc(25);
    chk(tripRelay, 4'hC);
    peerOc = 1'h0;
    drive(4'h0, 1'h0, 5);
    chk(tripRelay, 4'h0);
    bfOff = 1'h1;
    drive(4'h1, 1'h1, 3);
    chk({2'h0, tripRelay[1:0]}, 4'h3);
    drive(4'h0, 1'h0, 4);
    bfOff = 1'h0;
    peerArcOne = 1'h1;
    peerOc = 1'h1;
    cyc(5);
    chk({tripRelay[0], outOne, 2'h0}, 4'h8);
    peerArcOne = 1'h0;
    peerOc = 1'h0;
    magL2 = 8'h05;
    cyc(39950);
    chk({3'h0, unbal}, 4'h0);
    cyc(100);
    chk({3'h0, unbal}, 4'h1);
    chk(tripRelay, 4'h0);
    setMiddle = 8'h05;
    cyc(40100);
    chk({3'h0, unbal}, 4'h0);
    supplyValid = 1'h0;
    cyc(4);
    chk({3'h0, faultRelay}, 4'h0);
    supplyValid = 1'h1;
    kickOn = 1'h0;
    cyc(260);
    chk({2'h0, restartSeen, ctrlFault}, 4'h2);
    cyc(200);
    chk({2'h0, ctrlFault, faultRelay}, 4'h2);
    latchSwitch = 1'h0;
    drive(4'h1, 1'h1, 4);
    chk({3'h0, tripRelay[0]}, 4'h1);
    drive(4'h0, 1'h0, 5);
    chk({3'h0, tripRelay[0]}, 4'h0);
    tallyAndFinish();
  end
endmodule
